// File: common/rsc_map.vh
// Constants of the reset source controller: register offsets, field
// positions, reset patterns and counts.
// Assumes inclusion by bare name from the design file.
//
// Notes on behaviour
// - Sample reset pin at fourth machine-cycle phase
// - Internal reset applied synchronously to clock
// - Reset while pin high, two cycles after
// - No cause flag for external reset
// - Supply low resets; recovery reruns power-on delay
// - Time-out flag, reset 512 clocks later if enabled
// - Free-running watchdog, software clear restarts count
// - Watchdog reset held two machine cycles
// - Program counter held at zero; RAM untouched
// - Stack pointer loads 07h on reset
// - Port latches load FFh; port zero floats
// - Reset clears controls; watchdog off after power-on
// - Control register pattern depends on reset cause
// - Power-on flag set only by power-on
// - Power-fail flag set on fail, power-on loads the warning level
// - Watchdog-reset flag set by watchdog reset
// - Reset enable cleared only by power-on
// - Time-out flag set in monitor or timer use
// - Software may clear the power-on flag
// - Any reset forces four clocks per machine cycle
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RSC_ADDR_W 2
`define RSC_OFS_WDOG_CONTROL 2'h0
`define RSC_OFS_CTRL 2'h1
`define RSC_OFS_STATUS 2'h2

// ****************************************************************
// Watchdog control register field positions
// ****************************************************************
`define RSC_BIT_RESTART 0
`define RSC_BIT_WD_RESET_EN 1
`define RSC_BIT_WD_RESET_FLAG 2
`define RSC_BIT_WD_TIMEOUT_FLAG 3
`define RSC_BIT_POWER_FAIL_FLAG 4
`define RSC_BIT_POR_FLAG 6

// Control register fields
`define RSC_BIT_DIV_LO 0
`define RSC_BIT_DIV_HI 1
`define RSC_BIT_WD_RUN 2

// ****************************************************************
// Reset values and core init values
// ****************************************************************
`define RSC_WATCHDOG_CONTROL_AND_RESET_CAUSE_POR 8'h40
`define RSC_DIV_SEL_4 2'h1
`define RSC_DIV_SEL_64 2'h2
`define RSC_DIV_SEL_1024 2'h3
`define RSC_PC_INIT 16'h0000
`define RSC_SP_INIT 8'h07
`define RSC_PORT_INIT 8'hFF

// ****************************************************************
// Counts
// ****************************************************************
`define RSC_MC_LEN_4 10'h003
`define RSC_MC_LEN_64 10'h03F
`define RSC_MC_LEN_1024 10'h3FF
`define RSC_HOLD_MCYCLES 2'h2
`define RSC_WD_GRACE 10'h200
`define RSC_POR_DELAY 1024
`define RSC_WD_INTERVAL 65536

`endif

// File: verilog/rsc_top.v
// Reset source controller for an 8-bit core: machine-cycle timing,
// external pin sampling, supply and watchdog resets, cause register.
// Assumes all inputs synchronous to CLK and a core that reads the
// init values while CORE_RESET is high.
`include "rsc_map.vh"

module rsc_top #(
    parameter POR_DELAY = `RSC_POR_DELAY,
    parameter WD_INTERVAL = `RSC_WD_INTERVAL,
    parameter WD_W = 26
) (
    // Clock, reset and enable
    input wire CLK,
    input wire RSTN,
    input wire CE,
    // Reset requests from outside
    input wire RST_PIN,
    input wire SUPPLY_LOW,
    input wire PWR_FAIL_WARN,
    // Register port
    input wire [`RSC_ADDR_W-1:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    // Core side
    output wire CORE_RESET,
    output wire MCYCLE_END,
    output wire [1:0] DIV_SEL,
    output wire WDOG_TIMEOUT,
    output wire [15:0] PC_INIT,
    output wire [7:0] SP_INIT,
    output wire [7:0] PORT_INIT,
    output wire PORT0_DRIVE_EN
);

    // ****************************************************************
    // Reset state machine encoding
    // ****************************************************************
    localparam [4:0] ST_RUN = 5'b00001;
    localparam [4:0] ST_EXT = 5'b00010;
    localparam [4:0] ST_STRETCH = 5'b00100;
    localparam [4:0] ST_WDOG = 5'b01000;
    localparam [4:0] ST_POR = 5'b10000;

    reg [4:0] state;
    reg [1:0] hold_cnt;
    reg [31:0] por_cnt;
    reg [9:0] phase;
    reg [1:0] div_sel;
    reg wd_run;
    reg [WD_W-1:0] wd_cnt;
    reg [9:0] grace_cnt;
    reg grace_on;
    reg por_flag;
    reg power_fail_flag;
    reg wdog_timeout_flag;
    reg wdog_reset_flag;
    reg wdog_reset_enable;

    wire [9:0] mc_last;
    wire mc_end;
    wire running;
    wire wr_watchdog_control_and_reset_cause;
    wire wr_ctrl;
    wire wd_restart;
    wire wd_wrap;
    wire wd_fire;
    wire ext_entry;
    wire por_done;

    // ****************************************************************
    // Machine-cycle timing
    // ****************************************************************
    // Last phase index for the selected divider; reserved code acts as 4
    assign mc_last = (div_sel == `RSC_DIV_SEL_64) ? `RSC_MC_LEN_64 :
                     (div_sel == `RSC_DIV_SEL_1024) ? `RSC_MC_LEN_1024 :
                     `RSC_MC_LEN_4;
    assign mc_end = (phase == mc_last);
    assign running = state[0];

    // Phase counter; restarts if a shorter divider lands below phase, and
    // on a watchdog reset so the hold spans two whole machine cycles
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            phase <= 10'h000;
        end
        else if (CE)
        begin
            if ((running && wd_fire) || phase >= mc_last)
            begin
                phase <= 10'h000;
            end
            else
            begin
                phase <= phase + 10'h001;
            end
        end
    end

    // ****************************************************************
    // Register strobes and watchdog events
    // ****************************************************************
    assign wr_watchdog_control_and_reset_cause = WR && (ADDR == `RSC_OFS_WDOG_CONTROL);
    assign wr_ctrl = WR && (ADDR == `RSC_OFS_CTRL);
    assign wd_restart = wr_watchdog_control_and_reset_cause && WDATA[`RSC_BIT_RESTART] && running;
    assign wd_wrap = wd_run && running && !wd_restart &&
                     (wd_cnt == WD_INTERVAL[WD_W-1:0] - 1'b1);
    // Grace window expires unserviced with reset enabled
    assign wd_fire = grace_on && !wd_restart && wdog_reset_enable &&
                     (grace_cnt == `RSC_WD_GRACE - 10'h001);
    // Pin seen high only at the final phase of a machine cycle
    assign ext_entry = mc_end && RST_PIN;
    assign por_done = !SUPPLY_LOW && (por_cnt == POR_DELAY - 1);

    // ****************************************************************
    // Watchdog counter
    // ****************************************************************
    // Free-running while enabled; held clear in reset so a fresh
    // interval starts when execution resumes
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wd_cnt <= {WD_W{1'b0}};
            grace_cnt <= 10'h000;
            grace_on <= 1'b0;
        end
        else if (CE)
        begin
            if (!running || wd_restart || wd_fire)
            begin
                wd_cnt <= {WD_W{1'b0}};
                grace_cnt <= 10'h000;
                grace_on <= 1'b0;
            end
            else
            begin
                if (wd_run)
                begin
                    wd_cnt <= wd_wrap ? {WD_W{1'b0}} : wd_cnt + 1'b1;
                end
                if (wd_wrap && !grace_on)
                begin
                    grace_on <= 1'b1;
                    grace_cnt <= 10'h000;
                end
                else if (grace_on && grace_cnt != `RSC_WD_GRACE - 10'h001)
                begin
                    grace_cnt <= grace_cnt + 10'h001;
                end
            end
        end
    end

    // ****************************************************************
    // Reset sequencing
    // ****************************************************************
    // Supply loss outranks everything, then watchdog, then the pin.
    // Internal reset is a registered state, so it always follows a
    // clock edge and a stopped clock cannot apply it.
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state <= ST_POR;
            hold_cnt <= 2'h0;
            por_cnt <= 32'h0000_0000;
        end
        else if (CE)
        begin
            if (SUPPLY_LOW)
            begin
                state <= ST_POR;
                por_cnt <= 32'h0000_0000;
            end
            else
            begin
                case (state)
                    ST_RUN:
                    begin
                        hold_cnt <= 2'h0;
                        if (wd_fire)
                        begin
                            state <= ST_WDOG;
                        end
                        else if (ext_entry)
                        begin
                            state <= ST_EXT;
                        end
                    end
                    ST_EXT:
                    begin
                        hold_cnt <= 2'h0;
                        if (mc_end && !RST_PIN)
                        begin
                            state <= ST_STRETCH;
                        end
                    end
                    ST_STRETCH:
                    begin
                        if (ext_entry)
                        begin
                            state <= ST_EXT;
                            hold_cnt <= 2'h0;
                        end
                        else if (mc_end)
                        begin
                            if (hold_cnt == `RSC_HOLD_MCYCLES - 2'h1)
                            begin
                                state <= ST_RUN;
                            end
                            hold_cnt <= hold_cnt + 2'h1;
                        end
                    end
                    ST_WDOG:
                    begin
                        if (mc_end)
                        begin
                            if (hold_cnt == `RSC_HOLD_MCYCLES - 2'h1)
                            begin
                                state <= ext_entry ? ST_EXT : ST_RUN;
                            end
                            hold_cnt <= hold_cnt + 2'h1;
                        end
                    end
                    ST_POR:
                    begin
                        if (por_done)
                        begin
                            state <= ext_entry ? ST_EXT : ST_RUN;
                        end
                        else
                        begin
                            por_cnt <= por_cnt + 32'h0000_0001;
                        end
                    end
                    default:
                    begin
                        state <= ST_POR;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Control register: divider select and watchdog run
    // ****************************************************************
    // Divider drops back to four clocks on every reset cause; the
    // watchdog run bit survives all resets but power-on
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            div_sel <= `RSC_DIV_SEL_4;
            wd_run <= 1'b0;
        end
        else if (CE)
        begin
            if (SUPPLY_LOW || state[4])
            begin
                div_sel <= `RSC_DIV_SEL_4;
                wd_run <= 1'b0;
            end
            else if (!running || wd_fire || ext_entry)
            begin
                div_sel <= `RSC_DIV_SEL_4;
            end
            else if (wr_ctrl)
            begin
                div_sel <= WDATA[`RSC_BIT_DIV_HI:`RSC_BIT_DIV_LO];
                wd_run <= WDATA[`RSC_BIT_WD_RUN];
            end
        end
    end

    // ****************************************************************
    // Watchdog control and reset cause register
    // ****************************************************************
    // Hardware sets win over a software write in the same cycle
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            por_flag <= 1'b1;
            power_fail_flag <= 1'b0;
            wdog_timeout_flag <= 1'b0;
            wdog_reset_flag <= 1'b0;
            wdog_reset_enable <= 1'b0;
        end
        else if (CE)
        begin
            if (state[4] && por_done)
            begin
                // Power-on pattern once the supply is good again
                por_flag <= 1'b1;
                power_fail_flag <= PWR_FAIL_WARN;
                wdog_timeout_flag <= 1'b0;
                wdog_reset_flag <= 1'b0;
                wdog_reset_enable <= 1'b0;
            end
            else if (running && wd_fire)
            begin
                // Watchdog pattern: cause bit set, enable untouched
                wdog_reset_flag <= 1'b1;
                wdog_timeout_flag <= 1'b0;
                power_fail_flag <= power_fail_flag | PWR_FAIL_WARN;
            end
            else if (running && ext_entry)
            begin
                // External pattern: no cause flag of its own
                wdog_timeout_flag <= 1'b0;
                power_fail_flag <= power_fail_flag | PWR_FAIL_WARN;
            end
            else
            begin
                if (wr_watchdog_control_and_reset_cause && running)
                begin
                    por_flag <= WDATA[`RSC_BIT_POR_FLAG];
                    wdog_reset_flag <= WDATA[`RSC_BIT_WD_RESET_FLAG];
                    wdog_reset_enable <= WDATA[`RSC_BIT_WD_RESET_EN];
                end
                power_fail_flag <= PWR_FAIL_WARN ||
                    ((wr_watchdog_control_and_reset_cause && running) ? WDATA[`RSC_BIT_POWER_FAIL_FLAG] :
                    power_fail_flag);
                wdog_timeout_flag <= (wd_wrap && !grace_on) ||
                    ((wr_watchdog_control_and_reset_cause && running) ? WDATA[`RSC_BIT_WD_TIMEOUT_FLAG] :
                    wdog_timeout_flag);
            end
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Data stand only in the cycle after the strobe; unmapped reads zero
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            RDATA <= 8'h00;
        end
        else if (CE)
        begin
            RDATA <= 8'h00;
            if (RD && ADDR == `RSC_OFS_WDOG_CONTROL)
            begin
                RDATA <= {1'b0, por_flag, 1'b0, power_fail_flag,
                          wdog_timeout_flag, wdog_reset_flag,
                          wdog_reset_enable, 1'b0};
            end
            else if (RD && ADDR == `RSC_OFS_CTRL)
            begin
                RDATA <= {5'h00, wd_run, div_sel};
            end
            else if (RD && ADDR == `RSC_OFS_STATUS)
            begin
                RDATA <= {3'h0, state};
            end
        end
    end

    // ****************************************************************
    // Core-side outputs
    // ****************************************************************
    // Init values are constants the core loads while held in reset;
    // RAM has no connection here, so no reset can disturb it
    assign CORE_RESET = !running;
    assign MCYCLE_END = mc_end;
    assign DIV_SEL = div_sel;
    assign WDOG_TIMEOUT = wdog_timeout_flag;
    assign PC_INIT = `RSC_PC_INIT;
    assign SP_INIT = `RSC_SP_INIT;
    assign PORT_INIT = `RSC_PORT_INIT;
    assign PORT0_DRIVE_EN = running;

endmodule

// File: testbench/rsc_asserts.sv
// Checker for the reset source controller, watching top ports only.
// Assumes it is bound onto rsc_top with CE held high by the bench.
module rsc_asserts (
    // Clock and reset
    input wire CLK,
    input wire RSTN,
    // Requests and bus strobes
    input wire RST_PIN,
    input wire SUPPLY_LOW,
    input wire RD,
    // Outputs of the block
    input wire [7:0] RDATA,
    input wire CORE_RESET,
    input wire MCYCLE_END,
    input wire [1:0] DIV_SEL,
    input wire [15:0] PC_INIT,
    input wire [7:0] SP_INIT,
    input wire [7:0] PORT_INIT,
    input wire PORT0_DRIVE_EN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_pin_taken: assert property (MCYCLE_END && RST_PIN |=> CORE_RESET)
        else $error("Pin seen high at phase four but no reset");
    a_pin_holds: assert property ($fell(CORE_RESET) |-> !$past(RST_PIN))
        else $error("Reset left while pin still high");
    // Stretch counted from the first low sample after a high one
    a_ext_stretch: assert property (
        CORE_RESET && MCYCLE_END && !RST_PIN && $past(RST_PIN, 4)
        |-> ##8 CORE_RESET ##1 !CORE_RESET)
        else $error("Stretch after pin release has wrong length");
    a_init_consts: assert property (
        PC_INIT == 16'h0000 && SP_INIT == 8'h07 && PORT_INIT == 8'hFF)
        else $error("Init values wrong");
    a_port0_float: assert property (CORE_RESET |-> !PORT0_DRIVE_EN)
        else $error("Port zero driven in reset");
    a_div_four: assert property (CORE_RESET |=> DIV_SEL == 2'h1)
        else $error("Divider not four in reset");
    a_mcycle_four: assert property (
        CORE_RESET && MCYCLE_END |=> !MCYCLE_END [*3] ##1 MCYCLE_END)
        else $error("Machine cycle not four clocks in reset");
    // A rise with neither pin nor supply behind it is the watchdog
    a_wdog_hold: assert property (
        $rose(CORE_RESET) && !$past(RST_PIN) && !$past(SUPPLY_LOW)
        |-> CORE_RESET [*8] ##[0:4] !CORE_RESET)
        else $error("Watchdog reset length wrong");
    a_supply_rst: assert property (SUPPLY_LOW |=> CORE_RESET)
        else $error("Supply low without reset");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("Read data outside its cycle");

    // Main scenarios reached
    c_ext: cover property ($fell(RST_PIN) && CORE_RESET);
    c_wdog: cover property ($rose(CORE_RESET) && !$past(RST_PIN) && !$past(SUPPLY_LOW));
    c_read: cover property (RD ##1 RDATA != 8'h00);
endmodule

// File: testbench/rsc_partner.sv
// Model of the external reset source and the supply monitor.
// Assumes the bench calls one of its tasks at a time.
module rsc_partner (
    // Clock
    input wire clk,
    // Requests into the block
    output logic rst_pin,
    output logic supply_low,
    output logic pwr_fail_warn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet lines from time zero
    initial
    begin
        rst_pin = 1'b0;
        supply_low = 1'b0;
        pwr_fail_warn = 1'b0;
    end
    // Caller must give n of at least one machine cycle, or the sample may miss it
    task automatic pin_pulse(int n);
        @(posedge clk);
        rst_pin <= 1'b1;
        repeat (n) @(posedge clk);
        rst_pin <= 1'b0;
    endtask
    // Warning level is left standing after recovery, as a real monitor would
    task automatic supply_dip(int n, logic w);
        @(posedge clk);
        pwr_fail_warn <= w;
        supply_low <= 1'b1;
        repeat (n) @(posedge clk);
        supply_low <= 1'b0;
    endtask
endmodule

// File: testbench/rsc_top_bench.sv
// Self-checking bench of the reset source controller, with its checker bound.
// Assumes the partner model and checker are compiled before this file.
module rsc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    wire rst_pin, supply_low, pwr_fail_warn, core_reset, mcycle_end, wdog_timeout, port0_drive_en;
    wire [7:0] rdata, sp_init, port_init;
    wire [1:0] div_sel;
    wire [15:0] pc_init;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    // ****************************************************************
    // Block, partner and clock
    // ****************************************************************
    // Small counts keep the run short
    rsc_top #(.POR_DELAY(8), .WD_INTERVAL(64)) i_rsc_top (.CLK(clk), .RSTN(rstn), .CE(1'b1),
        .RST_PIN(rst_pin), .SUPPLY_LOW(supply_low), .PWR_FAIL_WARN(pwr_fail_warn),
        .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
        .CORE_RESET(core_reset), .MCYCLE_END(mcycle_end), .DIV_SEL(div_sel),
        .WDOG_TIMEOUT(wdog_timeout), .PC_INIT(pc_init), .SP_INIT(sp_init),
        .PORT_INIT(port_init), .PORT0_DRIVE_EN(port0_drive_en));
    rsc_partner i_rsc_partner (.clk(clk), .rst_pin(rst_pin), .supply_low(supply_low),
        .pwr_fail_warn(pwr_fail_warn));
    initial
    begin
        forever #2 clk = ~clk;
    end
    // Hang guard, far above the roughly 900 cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            final_report;
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(logic [1:0] a, logic [7:0] exp, string what);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask
    task automatic wait_rst(logic v, int lim);
        int n;
        n = 0;
        while (core_reset !== v && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("core_reset", v, core_reset);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_por;
        chk("reset_in_por", 1'b1, core_reset);
        chk("port0_en", 1'b0, port0_drive_en);
        chk("pc_init", 16'h0000, pc_init);
        chk("sp_init", 8'h07, sp_init);
        chk("port_init", 8'hFF, port_init);
        wait_rst(1'b0, 20);
        chk("port0_run", 1'b1, port0_drive_en);
        rd(2'h0, 8'h40, "watchdog_control_and_reset_cause_por");
        rd(2'h1, 8'h01, "ctrl_por");
        rd(2'h2, 8'h01, "status_run");
        rd(2'h3, 8'h00, "unmapped");
        wr(2'h3, 8'hFF);
        wr(2'h0, 8'h00);
        rd(2'h0, 8'h00, "por_flag_clear");
        $display("test por done");
    endtask
    // Slow divider first, so the reset must force it back to four
    task automatic t_ext;
        wr(2'h0, 8'h02);
        wr(2'h1, 8'h02);
        fork
            i_rsc_partner.pin_pulse(140);
        join_none
        wait_rst(1'b1, 200);
        wr(2'h1, 8'h06);
        #1;
        chk("div_in_reset", 2'h1, div_sel);
        wait_rst(1'b0, 300);
        rd(2'h0, 8'h02, "watchdog_control_and_reset_cause_ext");
        rd(2'h1, 8'h01, "ctrl_ext");
        $display("test ext done");
    endtask
    task automatic t_wdog;
        int n;
        wr(2'h1, 8'h05);
        repeat (40) @(posedge clk);
        wr(2'h0, 8'h03);
        repeat (40) @(posedge clk);
        #1;
        chk("timeout_after_clear", 1'b0, wdog_timeout);
        n = 0;
        while (wdog_timeout !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("timeout_set", 1'b1, wdog_timeout);
        rd(2'h0, 8'h0A, "watchdog_control_and_reset_cause_timeout");
        n = 2;
        while (core_reset !== 1'b1 && n < 600)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("grace_in_range", 1'b1, n >= 511 && n <= 514);
        wait_rst(1'b0, 20);
        rd(2'h0, 8'h06, "watchdog_control_and_reset_cause_wdog");
        $display("test wdog done");
    endtask
    task automatic t_sup;
        i_rsc_partner.supply_dip(10, 1'b1);
        wait_rst(1'b1, 2);
        wait_rst(1'b0, 20);
        rd(2'h0, 8'h50, "watchdog_control_and_reset_cause_fail");
        rd(2'h1, 8'h01, "ctrl_fail");
        // Clear the power-on flag so the next dip must set it again
        wr(2'h0, 8'h00);
        rd(2'h0, 8'h10, "fail_set_wins");
        i_rsc_partner.supply_dip(10, 1'b0);
        wait_rst(1'b1, 2);
        wait_rst(1'b0, 30);
        rd(2'h0, 8'h40, "watchdog_control_and_reset_cause_por2");
        $display("test supply done");
    endtask
    task automatic final_report;
        $display("Counts: %0d compared, %0d mismatched", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        #1;
        t_por;
        t_ext;
        t_wdog;
        t_sup;
        final_report;
    end
endmodule

bind rsc_top rsc_asserts i_rsc_asserts (.CLK(CLK), .RSTN(RSTN), .RST_PIN(RST_PIN),
    .SUPPLY_LOW(SUPPLY_LOW), .RD(RD), .RDATA(RDATA), .CORE_RESET(CORE_RESET),
    .MCYCLE_END(MCYCLE_END), .DIV_SEL(DIV_SEL), .PC_INIT(PC_INIT), .SP_INIT(SP_INIT),
    .PORT_INIT(PORT_INIT), .PORT0_DRIVE_EN(PORT0_DRIVE_EN));
